// ==== safe_cfg.svh ====
`ifndef SAFE_CFG_SVH
`define SAFE_CFG_SVH
`define SAFE_OFF_RATE 8'h00
`define SAFE_OFF_MASK 8'h04
`define SAFE_OFF_EXC 8'h08
`define SAFE_OFF_TGAIN 8'h0c
`define SAFE_OFF_PRES 8'h10
`define SAFE_OFF_TEMP 8'h14
`define SAFE_OFF_TROUTE 8'h18
`define SAFE_OFF_TRIM 8'h1c
`define SAFE_OFF_FILT 8'h20
`define SAFE_OFF_STATUS 8'h24
`define SAFE_RST_RATE 4'h0
`define SAFE_RST_MASK 10'h0ff
`define SAFE_RST_EXC 3'h0
`define SAFE_RST_TGAIN 8'h00
`define SAFE_RST_TROUTE 5'h00
`define SAFE_RST_TRIM 3'h0
`define SAFE_RST_FILT 2'h0
`define SAFE_BIT_TRDY 9
`define SAFE_BIT_PRDY 8
`define SAFE_BIT_EXC_UV 7
`define SAFE_BIT_EXC_OV 6
`define SAFE_BIT_TP_UV 5
`define SAFE_BIT_TP_OV 4
`define SAFE_BIT_EXC_FAULT 11
`define SAFE_BIT_TP_FAULT 10
`define SAFE_CLK_MHZ 100
`define SAFE_SW_1K_NS 500000
`define SAFE_SW_1K_CYC ((`SAFE_SW_1K_NS * `SAFE_CLK_MHZ) / 1000)
`endif

// ==== safe_pkg.sv ====
package safe_pkg;
  typedef enum logic [2:0] {
    SAFE_EXC_OFF = 3'h0,
    SAFE_EXC_CURRENT = 3'h1,
    SAFE_EXC_V4P0 = 3'h2,
    SAFE_EXC_V3P3 = 3'h3,
    SAFE_EXC_V1P8 = 3'h4,
    SAFE_EXC_V2P3 = 3'h5
  } safe_exc_type;
  typedef enum logic [2:0] {
    SAFE_SEQ_PRES = 3'h0,
    SAFE_SEQ_PGAP = 3'h1,
    SAFE_SEQ_SWT = 3'h3,
    SAFE_SEQ_TEMP = 3'h2,
    SAFE_SEQ_SWP = 3'h6
  } safe_seq_type;
  typedef enum logic [2:0] {
    SAFE_TR_INT_SE1 = 3'h0,
    SAFE_TR_INT_SEG = 3'h1,
    SAFE_TR_INT_DIFF = 3'h2,
    SAFE_TR_EXC_SE1 = 3'h3,
    SAFE_TR_EXC_DIFF = 3'h4,
    SAFE_TR_NONE = 3'h7
  } safe_troute_type;
endpackage : safe_pkg

// ==== safe_cnv_if.sv ====
interface safe_cnv_if;
  logic pres_start;
  logic temp_start;
  logic pres_done;
  logic temp_done;
  logic [15:0] pres_data;
  logic [15:0] temp_data;
  modport seq (output pres_start, output temp_start, input pres_done,
    input temp_done, input pres_data, input temp_data);
  modport core (input pres_start, input temp_start, output pres_done,
    output temp_done, output pres_data, output temp_data);
endinterface : safe_cnv_if

// ==== safe_conv_seq.sv ====
`include "safe_cfg.svh"
module safe_conv_seq #(
  parameter int unsigned SW_1K_CYC = `SAFE_SW_1K_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] rate_sel,
  safe_cnv_if.seq cnv,
  output logic [2:0] phase
);
  import safe_pkg::*;
  safe_seq_type st_r;
  logic [31:0] cnt_r;
  logic [31:0] sw_cyc;
  logic [31:0] per_cyc;
  logic [31:0] tdiv_r;
  logic [31:0] tdiv_lim;
  logic temp_due_r;
  // Switch time halves with each pressure rate step up to step 4; steps 5 to 7 keep the step 4 time
  always_comb begin
    sw_cyc = 32'(SW_1K_CYC) >> rate_sel[3:1];
    if (rate_sel[3:1] > 3'h4) begin
      sw_cyc = 32'(SW_1K_CYC) >> 4;
    end
    if (sw_cyc == 32'h0) begin
      sw_cyc = 32'h1;
    end
    per_cyc = sw_cyc << 1;
    tdiv_lim = rate_sel[0] ? 32'd100 : 32'd1000;
  end
  assign phase = st_r;
  assign cnv.pres_start = (st_r == SAFE_SEQ_PRES);
  // Temperature slot is always walked so the pressure period never changes
  assign cnv.temp_start = (st_r == SAFE_SEQ_TEMP) && temp_due_r;
  // Temperature due counts pressure periods, never stalling pressure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tdiv_r <= 32'h0;
      temp_due_r <= 1'b0;
    end else if (st_r == SAFE_SEQ_PRES) begin
      if (tdiv_r + 32'h1 >= tdiv_lim) begin
        tdiv_r <= 32'h0;
        temp_due_r <= 1'b1;
      end else begin
        tdiv_r <= tdiv_r + 32'h1;
      end
    end else if (st_r == SAFE_SEQ_TEMP) begin
      temp_due_r <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= SAFE_SEQ_PRES;
      cnt_r <= 32'h0;
    end else begin
      case (st_r)
        SAFE_SEQ_PRES: begin
          cnt_r <= 32'h0;
          st_r <= SAFE_SEQ_PGAP;
        end
        SAFE_SEQ_PGAP: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r + 32'h1 >= sw_cyc) begin
            cnt_r <= 32'h0;
            st_r <= SAFE_SEQ_SWT;
          end
        end
        SAFE_SEQ_SWT: begin
          st_r <= SAFE_SEQ_TEMP;
        end
        SAFE_SEQ_TEMP: begin
          st_r <= SAFE_SEQ_SWP;
        end
        SAFE_SEQ_SWP: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r + 32'h3 >= sw_cyc) begin
            st_r <= SAFE_SEQ_PRES;
          end
        end
        default: st_r <= SAFE_SEQ_PRES;
      endcase
    end
  end
  logic unused_ok;
  assign unused_ok = &{1'b0, per_cyc[0]};
endmodule : safe_conv_seq

// ==== safe_regs.sv ====
// Design decisions made here: the AXI4-Lite register port and the address map.
`include "safe_cfg.svh"
module safe_regs #(
  parameter int unsigned SW_1K_CYC = `SAFE_SW_1K_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] fault_in,
  input wire logic excite_fault_in,
  input wire logic temp_pin_fault_in,
  input wire logic pres_done,
  input wire logic temp_done,
  input wire logic [15:0] pres_data,
  input wire logic [15:0] temp_data,
  output logic pres_start,
  output logic temp_start,
  output logic [2:0] seq_phase,
  output logic alert_n,
  output safe_pkg::safe_exc_type excitation_mode,
  output logic adc_ref_bridge,
  output logic [3:0] temp_gain_code,
  output logic [2:0] pres_rate_code,
  output logic temp_rate_fast,
  output safe_pkg::safe_troute_type temp_route,
  output logic [1:0] excite_scale,
  output logic trim_res_connect,
  output logic offset_isrc_on,
  output logic pres_amp_bypass,
  output logic [1:0] filter_bw
);
  import safe_pkg::*;
  logic [3:0] rate_r;
  logic [9:0] mask_r;
  logic [2:0] exc_r;
  logic [7:0] tgain_r;
  logic [15:0] pres_r;
  logic [15:0] temp_r;
  logic [4:0] troute_r;
  logic [2:0] trim_r;
  logic [1:0] filt_r;
  logic [11:0] stat_r;
  logic [11:0] stat_set;
  logic [11:0] stat_clr;
  logic [7:0] aw_r;
  logic aw_ok_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  logic w_ok_r;
  logic wr_go;
  logic [31:0] rd_nxt;
  logic rd_err;
  logic [9:0] f_s1_r;
  logic [9:0] f_s2_r;
  logic [9:0] f_s3_r;
  logic [9:0] f_q_r;
  logic alert_r;
  safe_cnv_if cnv ();
  assign cnv.pres_done = pres_done;
  assign cnv.temp_done = temp_done;
  assign cnv.pres_data = pres_data;
  assign cnv.temp_data = temp_data;
  assign pres_start = cnv.pres_start;
  assign temp_start = cnv.temp_start;
  safe_conv_seq #(.SW_1K_CYC(SW_1K_CYC)) u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .rate_sel(rate_r),
    .cnv(cnv.seq),
    .phase(seq_phase)
  );
  // Write channel: address and data taken independently, in any order
  assign s_axi_awready = !aw_ok_r;
  assign s_axi_wready = !w_ok_r;
  assign wr_go = aw_ok_r && w_ok_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      aw_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_r <= 1'b1;
      aw_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_ok_r <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_ok_r <= 1'b0;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_ok_r <= 1'b1;
      wd_r <= s_axi_wdata;
      ws_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_ok_r <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      case (aw_r)
        `SAFE_OFF_RATE, `SAFE_OFF_MASK, `SAFE_OFF_EXC, `SAFE_OFF_TGAIN,
        `SAFE_OFF_TROUTE, `SAFE_OFF_TRIM, `SAFE_OFF_FILT,
        `SAFE_OFF_STATUS, `SAFE_OFF_PRES, `SAFE_OFF_TEMP:
          s_axi_bresp <= 2'h0;
        default: s_axi_bresp <= 2'h2;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Configuration registers; result registers ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_r <= `SAFE_RST_RATE;
      mask_r <= `SAFE_RST_MASK;
      exc_r <= `SAFE_RST_EXC;
      tgain_r <= `SAFE_RST_TGAIN;
      troute_r <= `SAFE_RST_TROUTE;
      trim_r <= `SAFE_RST_TRIM;
      filt_r <= `SAFE_RST_FILT;
    end else if (wr_go) begin
      case (aw_r)
        `SAFE_OFF_RATE: if (ws_r[0]) rate_r <= wd_r[3:0];
        `SAFE_OFF_MASK: begin
          if (ws_r[0]) mask_r[7:0] <= wd_r[7:0];
          if (ws_r[1]) mask_r[9:8] <= wd_r[9:8];
        end
        `SAFE_OFF_EXC: if (ws_r[0]) exc_r <= wd_r[2:0];
        `SAFE_OFF_TGAIN: if (ws_r[0]) tgain_r <= wd_r[7:0];
        `SAFE_OFF_TROUTE: if (ws_r[0]) troute_r <= wd_r[4:0];
        `SAFE_OFF_TRIM: if (ws_r[0]) trim_r <= wd_r[2:0];
        `SAFE_OFF_FILT: if (ws_r[0]) filt_r <= wd_r[1:0];
        default: ;
      endcase
    end
  end
  // Results latch only on a finished conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pres_r <= 16'h0000;
    end else if (pres_done) begin
      pres_r <= pres_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_r <= 16'h0000;
    end else if (temp_done) begin
      temp_r <= temp_data;
    end
  end
  // Fault pins are asynchronous: three stages, change counted when 2 and 3 agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      f_s1_r <= 10'h000;
      f_s2_r <= 10'h000;
      f_s3_r <= 10'h000;
      f_q_r <= 10'h000;
    end else begin
      f_s1_r <= {excite_fault_in, temp_pin_fault_in, fault_in};
      f_s2_r <= f_s1_r;
      f_s3_r <= f_s2_r;
      for (int i = 0; i < 10; i++) begin
        if (f_s2_r[i] == f_s3_r[i]) begin
          f_q_r[i] <= f_s3_r[i];
        end
      end
    end
  end
  always_comb begin
    stat_set = {f_q_r[9:8], temp_done, pres_done, f_q_r[7:0]};
    stat_clr = 12'h000;
    if (wr_go && aw_r == `SAFE_OFF_STATUS) begin
      stat_clr = {ws_r[1] ? wd_r[11:8] : 4'h0, ws_r[0] ? wd_r[7:0] : 8'h00};
    end
  end
  // Set wins over a clear landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= 12'h000;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= |(stat_r[9:0] & mask_r)
        | stat_r[`SAFE_BIT_EXC_FAULT] | stat_r[`SAFE_BIT_TP_FAULT];
    end
  end
  assign alert_n = !alert_r;
  always_comb begin
    rd_err = 1'b0;
    rd_nxt = 32'h0;
    case (s_axi_araddr)
      `SAFE_OFF_RATE: rd_nxt = {28'h0, rate_r};
      `SAFE_OFF_MASK: rd_nxt = {22'h0, mask_r};
      `SAFE_OFF_EXC: rd_nxt = {29'h0, exc_r};
      `SAFE_OFF_TGAIN: rd_nxt = {24'h0, tgain_r};
      `SAFE_OFF_PRES: rd_nxt = {16'h0, pres_r};
      `SAFE_OFF_TEMP: rd_nxt = {16'h0, temp_r};
      `SAFE_OFF_TROUTE: rd_nxt = {27'h0, troute_r};
      `SAFE_OFF_TRIM: rd_nxt = {29'h0, trim_r};
      `SAFE_OFF_FILT: rd_nxt = {30'h0, filt_r};
      `SAFE_OFF_STATUS: rd_nxt = {20'h0, stat_r};
      default: rd_err = 1'b1;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_nxt;
      s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // Undefined excitation codes fall back to disconnected
  always_comb begin
    case (exc_r)
      3'h1: excitation_mode = SAFE_EXC_CURRENT;
      3'h2: excitation_mode = SAFE_EXC_V4P0;
      3'h3: excitation_mode = SAFE_EXC_V3P3;
      3'h4: excitation_mode = SAFE_EXC_V1P8;
      3'h5: excitation_mode = SAFE_EXC_V2P3;
      default: excitation_mode = SAFE_EXC_OFF;
    endcase
  end
  assign adc_ref_bridge = (excitation_mode != SAFE_EXC_CURRENT) &&
    (excitation_mode != SAFE_EXC_OFF);
  assign temp_gain_code = tgain_r[3:0];
  assign pres_rate_code = rate_r[3:1];
  assign temp_rate_fast = rate_r[0];
  always_comb begin
    case (troute_r[2:0])
      3'h0: temp_route = SAFE_TR_INT_SE1;
      3'h1: temp_route = SAFE_TR_INT_SEG;
      3'h2: temp_route = SAFE_TR_INT_DIFF;
      3'h3: temp_route = SAFE_TR_EXC_SE1;
      3'h4: temp_route = SAFE_TR_EXC_DIFF;
      default: temp_route = SAFE_TR_NONE;
    endcase
  end
  assign excite_scale = troute_r[4:3];
  assign trim_res_connect = trim_r[2];
  assign offset_isrc_on = trim_r[1];
  assign pres_amp_bypass = trim_r[0];
  assign filter_bw = filt_r;
endmodule : safe_regs

// ==== safe_conv_model.sv ====
module safe_conv_model #(
  parameter int LAT = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pres_start,
  input wire logic temp_start,
  input wire logic [15:0] pres_val,
  input wire logic [15:0] temp_val,
  output logic pres_done,
  output logic temp_done,
  output logic [15:0] pres_data,
  output logic [15:0] temp_data
);
  logic [7:0] pcnt_r;
  logic [7:0] tcnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) pcnt_r <= 8'h00;
    else if (pres_start) pcnt_r <= 8'(LAT);
    else if (pcnt_r != 8'h00) pcnt_r <= pcnt_r - 8'h01;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) tcnt_r <= 8'h00;
    else if (temp_start) tcnt_r <= 8'(LAT);
    else if (tcnt_r != 8'h00) tcnt_r <= tcnt_r - 8'h01;
  end
  assign pres_done = (pcnt_r == 8'h01);
  assign temp_done = (tcnt_r == 8'h01);
  // Data is only valid with done; otherwise show the inverse so stale
  // sampling is caught
  assign pres_data = pres_done ? pres_val : ~pres_val;
  assign temp_data = temp_done ? temp_val : ~temp_val;
endmodule : safe_conv_model

// ==== safe_regs_sva.sv ====
module safe_regs_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic excite_fault_in,
  input wire logic temp_pin_fault_in,
  input wire logic pres_start,
  input wire logic temp_start,
  input wire logic alert_n,
  input wire safe_pkg::safe_exc_type excitation_mode,
  input wire logic adc_ref_bridge,
  input wire logic [2:0] pres_rate_code
);
  import safe_pkg::*;
  logic [2:0] rc_r;
  logic [15:0] cnt_r;
  logic [15:0] per_r;
  logic [1:0] seen_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    rc_r <= pres_rate_code;
  end
  // Period is only compared after a few starts at one rate, so a rate
  // change may take effect in the middle of a period
  always_ff @(posedge aclk) begin
    if (!aresetn || pres_rate_code != rc_r) begin
      cnt_r <= 16'h0000;
      seen_r <= 2'h0;
    end else if (pres_start) begin
      cnt_r <= 16'h0001;
      per_r <= cnt_r;
      if (seen_r != 2'h3) seen_r <= seen_r + 2'h1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  property p_pres_steady;
    pres_start && seen_r == 2'h3 |-> cnt_r == per_r;
  endproperty
  a_pres_steady: assert property (p_pres_steady)
    else $error("pressure start period changed");
  property p_no_overlap;
    !(pres_start && temp_start);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("pressure and temperature start together");
  property p_exc_alert;
    excite_fault_in [*8] |-> !alert_n;
  endproperty
  a_exc_alert: assert property (p_exc_alert)
    else $error("alert missing for excitation pin fault");
  property p_tp_alert;
    temp_pin_fault_in [*8] |-> !alert_n;
  endproperty
  a_tp_alert: assert property (p_tp_alert)
    else $error("alert missing for temperature pin fault");
  property p_ref;
    adc_ref_bridge == (excitation_mode inside {SAFE_EXC_V4P0,
      SAFE_EXC_V3P3, SAFE_EXC_V1P8, SAFE_EXC_V2P3});
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference select does not follow excitation");
  property p_exc_legal;
    excitation_mode <= SAFE_EXC_V2P3;
  endproperty
  a_exc_legal: assert property (p_exc_legal)
    else $error("undefined excitation code reached output");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
  property p_b_answer;
    s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("write answer late");
endmodule : safe_regs_sva
bind safe_regs safe_regs_sva chk_u (.*);

// ==== test_sensor_afe_config_registers.sv ====
module test_sensor_afe_config_registers;
  timeunit 1ns;
  timeprecision 1ns;
  import safe_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic excite_fault_in = 1'b0, temp_pin_fault_in = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fault_in = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] pres_val = 16'h0000, temp_val = 16'h0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pres_start, temp_start, alert_n, adc_ref_bridge, temp_rate_fast;
  logic trim_res_connect, offset_isrc_on, pres_amp_bypass, pres_done, temp_done;
  logic [1:0] s_axi_bresp, s_axi_rresp, excite_scale, filter_bw;
  logic [31:0] s_axi_rdata, rd, e;
  logic [15:0] pres_data, temp_data;
  logic [2:0] seq_phase, pres_rate_code;
  logic [3:0] temp_gain_code;
  logic [65:0] note;
  logic [65:0] exp_q[$];
  safe_exc_type excitation_mode;
  safe_troute_type temp_route;
  int num_errors = 0, num_checks = 0, seed = 32'h371d, i;

  safe_regs #(.SW_1K_CYC(16)) dut_u (.*);
  safe_conv_model #(.LAT(1)) model_u (.*);

  always #5 aclk = ~aclk;

  task end_sim;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task fail(input string m);
    num_errors++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : fail
  task chk(input logic [31:0] g, input logic [31:0] x, input string m);
    num_checks++;
    if (g !== x) fail(m);
  endtask : chk
  // Waits for a handshake or done flag, sampled at the falling edge
  task wt(input int k, input int lim);
    int n;
    logic h;
    h = 1'b0;
    for (n = 0; !h && n < lim; n++) begin
      @(negedge aclk);
      case (k)
        0: h = s_axi_awready && s_axi_wready;
        1: h = s_axi_bvalid;
        2: h = s_axi_arready;
        3: h = s_axi_rvalid;
        4: h = pres_done;
        default: h = temp_done;
      endcase
      rd = s_axi_rdata;
      @(posedge aclk);
    end
    if (!h) begin
      fail("timeout");
      end_sim;
    end
  endtask : wt
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({32'h0, r, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wt(0, 50);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    wt(1, 50);
    s_axi_bready <= 1'b0;
  endtask : axw
  task axr(input logic [7:0] a, input logic [31:0] m, input logic [33:0] x);
    exp_q.push_back({m, x});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wt(2, 50);
    s_axi_arvalid <= 1'b0;
    wt(3, 50);
    s_axi_rready <= 1'b0;
  endtask : axr

  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      if (exp_q.size() == 0) fail("unexpected response");
      else begin
        note = exp_q.pop_front();
        chk(32'(s_axi_rvalid ? s_axi_rresp : s_axi_bresp), 32'(note[33:32]),
          "response code");
        if (s_axi_rvalid) chk(s_axi_rdata & note[65:34], note[31:0], "rdata");
      end
    end
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h04, 32'hffffffff, {2'h0, 32'h0ff});
    chk(32'(excitation_mode), 32'(SAFE_EXC_OFF), "exc reset");
    for (i = 0; i < 8; i++) begin
      axw(8'h08, 32'(i), 2'h0);
      chk(32'(excitation_mode), (i > 5) ? 0 : i, "exc decode");
      chk(32'(adc_ref_bridge), 32'(i > 1 && i < 6), "ref select");
    end
    e = $random(seed);
    axw(8'h0c, e, 2'h0);
    chk(32'(temp_gain_code), 32'(e[3:0]), "gain code");
    axr(8'h0c, 32'hffffffff, {2'h0, 24'h0, e[7:0]});
    for (i = 0; i < 8; i++) begin
      e = {$random(seed)} & 32'h18 | i;
      axw(8'h18, e, 2'h0);
      chk(32'(temp_route), (i > 4) ? 7 : i, "route");
      chk(32'(excite_scale), 32'(e[4:3]), "scale");
      axw(8'h1c, 32'(i), 2'h0);
      chk({trim_res_connect, offset_isrc_on, pres_amp_bypass}, i, "trim");
      axw(8'h20, 32'(i[1:0]), 2'h0);
      chk(32'(filter_bw), 32'(i[1:0]), "filter");
    end
    for (i = 0; i < 10; i++) begin
      axw(8'h00, 32'(i), 2'h0);
      chk({pres_rate_code, temp_rate_fast}, i, "rate");
    end
    axw(8'h00, 32'h1, 2'h0);
    axr(8'h28, 32'h0, {2'h2, 32'h0});
    axw(8'h28, 32'h5, 2'h2);
    for (i = 0; i < 3; i++) begin
      pres_val <= (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : 16'h0000;
      axw(8'h10, 32'h1111, 2'h0);
      wt(4, 500);
      axr(8'h10, 32'hffff, {2'h0, 16'h0, pres_val});
    end
    temp_val <= 16'($random(seed));
    wt(5, 20000);
    axw(8'h14, 32'h2222, 2'h0);
    axr(8'h14, 32'hffff, {2'h0, 16'h0, temp_val});
    axw(8'h04, 32'h0, 2'h0);
    fault_in <= 8'hff;
    repeat (10) @(posedge aclk);
    chk(32'(alert_n), 32'h1, "masked flag alerted");
    axw(8'h04, 32'h080, 2'h0);
    repeat (6) @(posedge aclk);
    chk(32'(alert_n), 32'h0, "enabled flag silent");
    axw(8'h04, 32'h0, 2'h0);
    fault_in <= 8'h00;
    excite_fault_in <= 1'b1;
    temp_pin_fault_in <= 1'b1;
    repeat (10) @(posedge aclk);
    chk(32'(alert_n), 32'h0, "pin fault silent");
    excite_fault_in <= 1'b0;
    temp_pin_fault_in <= 1'b0;
    repeat (8) @(posedge aclk);
    axr(8'h24, 32'h0, 34'h0);
    axw(8'h24, rd, 2'h0);
    repeat (3) @(posedge aclk);
    chk(32'(alert_n), 32'h1, "alert after clear");
    end_sim;
  end
endmodule : test_sensor_afe_config_registers
